// file: tptc_cfg.svh
`ifndef TPTC_CFG_SVH
`define TPTC_CFG_SVH
// register offsets
`define TPTC_OFS_DRV 8'hf0
`define TPTC_OFS_CSR 8'hf1
`define TPTC_OFS_WADR 8'hf2
`define TPTC_OFS_WDAT 8'hf3
`define TPTC_OFS_NTRIM 8'hf4
`define TPTC_OFS_PTRIM 8'hf5
`define TPTC_OFS_FSEL 8'hf6
`define TPTC_OFS_ISTAT 8'hf7
`define TPTC_OFS_IMASK 8'hff
// reset values
`define TPTC_RST_DRV 8'h80
`define TPTC_RST_CSR 2'h1
`define TPTC_RST_WADR 8'h00
`define TPTC_RST_TRIM 7'h00
// field positions and codes
`define TPTC_BIT_FLOAT 7
`define TPTC_BIT_OVF 2
`define TPTC_SCALE_FULL 5'h15
`define TPTC_SCALE_MAXSTEP 5'h14
// template geometry
`define TPTC_UI_COUNT 5
`define TPTC_TAP_COUNT 24
`define TPTC_ENTRIES 120
// interrupt status bits
`define TPTC_INT_OVF 0
`define TPTC_INT_COPY 1
`endif

// file: tptc_pkg.sv
package tptc_pkg;
   // amplitude decode result, gray ordered
   typedef enum logic [1:0] {
      TPTC_AMP_FLOAT = 2'h0,
      TPTC_AMP_STEP = 2'h1,
      TPTC_AMP_FULL = 2'h3,
      TPTC_AMP_RSVD = 2'h2
   } tptc_amp_t;
   typedef logic [6:0] tptc_trim_t;
   typedef logic signed [6:0] tptc_tmpl_t;
endpackage : tptc_pkg

// file: tptc_ctrl.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "tptc_cfg.svh"
module tptc_ctrl #(
   parameter int DAC_MAX = 127
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // transmit line control
   input wire logic tx_line_unit_hold,
   input wire logic fuse_program_pin,
   input wire logic analog_test_pin,
   input wire logic [1:0][5:0] fuse_burned,
   // waveform sample request
   input wire logic sample_valid,
   input wire logic [4:0] sample_tap,
   input wire logic [4:0] sample_ui_mark,
   // line driver
   output logic line_float,
   output tptc_pkg::tptc_amp_t amp_mode,
   output logic [4:0] amp_steps,
   output logic signed [7:0] dac_code,
   // trim, index 0 sink converter, 1 source converter
   output logic [1:0][4:0] trim_mag,
   output logic [1:0] trim_neg,
   output logic [1:0] trim_override,
   output logic [1:0][5:0] fuse_blow,
   output logic [1:0] fuse_sense_en,
   // interrupt
   output logic irq
);
   import tptc_pkg::*;

   localparam logic signed [9:0] SUM_MAX = 10'(DAC_MAX);
   localparam logic signed [9:0] SUM_MIN = -SUM_MAX;

   // sign-magnitude to two's complement
   function automatic tptc_tmpl_t sm_to_tc(input logic [6:0] v);
      logic signed [6:0] mag;
      mag = {1'b0, v[5:0]};
      return v[6] ? -mag : mag;
   endfunction : sm_to_tc

   logic [7:0] drv_reg;
   logic [1:0] csr_rsv_reg;
   logic ovf_reg;
   logic [7:0] wadr_reg;
   logic fsel_reg;
   tptc_trim_t trim_reg [2];
   logic armed_reg [2];
   logic [1:0] istat_reg;
   logic [1:0] imask_reg;
   tptc_tmpl_t tmpl_mem [`TPTC_ENTRIES];
   logic [1:0] fpin_sync_reg;
   logic [1:0] atm_sync_reg;
   logic [7:0] rdata_reg;
   logic float_reg;
   tptc_amp_t amp_mode_reg;
   logic [4:0] amp_steps_reg;
   logic signed [7:0] dac_code_reg;
   logic [1:0][4:0] trim_mag_reg;
   logic [1:0] trim_neg_reg;
   logic [1:0] trim_ovr_reg;
   logic [1:0][5:0] fuse_blow_reg;
   logic irq_reg;

   wire hold = tx_line_unit_hold;

   // pin synchronisers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fpin_sync_reg <= 2'h0;
         atm_sync_reg <= 2'h0;
      end else begin
         fpin_sync_reg <= {fpin_sync_reg[0], fuse_program_pin};
         atm_sync_reg <= {atm_sync_reg[0], analog_test_pin};
      end
   end
   wire fpin_s = fpin_sync_reg[1];
   wire atm_s = atm_sync_reg[1];

   // address decode
   wire wr_drv = reg_wr && (reg_addr == `TPTC_OFS_DRV);
   wire wr_csr = reg_wr && (reg_addr == `TPTC_OFS_CSR);
   wire rd_csr = reg_rd && (reg_addr == `TPTC_OFS_CSR);
   wire wr_wadr = reg_wr && (reg_addr == `TPTC_OFS_WADR);
   wire wr_wdat = reg_wr && (reg_addr == `TPTC_OFS_WDAT);
   wire wr_fsel = reg_wr && (reg_addr == `TPTC_OFS_FSEL);
   wire wr_istat = reg_wr && (reg_addr == `TPTC_OFS_ISTAT);
   wire wr_imask = reg_wr && (reg_addr == `TPTC_OFS_IMASK);

   // template write address check
   wire [2:0] wa_ui = wadr_reg[2:0];
   wire [4:0] wa_tap = wadr_reg[7:3];
   wire wa_ok = (wa_ui < 3'(`TPTC_UI_COUNT)) && (wa_tap < 5'(`TPTC_TAP_COUNT));
   wire [6:0] wa_idx = 7'(wa_ui) * 7'(`TPTC_TAP_COUNT) + 7'(wa_tap);
   wire tmpl_we = wr_wdat && wa_ok;
   wire tptc_tmpl_t wr_val = sm_to_tc(reg_wdata[6:0]);

   // configuration registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         drv_reg <= `TPTC_RST_DRV;
         csr_rsv_reg <= `TPTC_RST_CSR;
         wadr_reg <= `TPTC_RST_WADR;
         fsel_reg <= 1'b0;
         imask_reg <= 2'h0;
      end else if (hold) begin
         drv_reg <= `TPTC_RST_DRV;
         csr_rsv_reg <= `TPTC_RST_CSR;
         wadr_reg <= `TPTC_RST_WADR;
         fsel_reg <= 1'b0;
         imask_reg <= 2'h0;
      end else begin
         if (wr_drv) drv_reg <= {reg_wdata[7], 2'h0, reg_wdata[4:0]};
         if (wr_csr) csr_rsv_reg <= reg_wdata[1:0];
         if (wr_wadr) wadr_reg <= reg_wdata;
         if (wr_fsel) fsel_reg <= reg_wdata[0];
         if (wr_imask) imask_reg <= reg_wdata[1:0];
      end
   end

   // template storage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `TPTC_ENTRIES; i++) tmpl_mem[i] <= 7'sh0;
      end else if (hold) begin
         for (int i = 0; i < `TPTC_ENTRIES; i++) tmpl_mem[i] <= 7'sh0;
      end else if (tmpl_we) begin
         tmpl_mem[wa_idx] <= wr_val;
      end
   end

   // five interval summation
   logic signed [9:0] term [`TPTC_UI_COUNT];
   wire tap_ok = sample_tap < 5'(`TPTC_TAP_COUNT);
   for (genvar g = 0; g < `TPTC_UI_COUNT; g++) begin : g_term
      wire [6:0] ridx = 7'(g * `TPTC_TAP_COUNT) + 7'(sample_tap);
      assign term[g] = (sample_ui_mark[g] && tap_ok) ? 10'(tmpl_mem[ridx]) : 10'sh0;
   end
   wire signed [9:0] sum = term[0] + term[1] + term[2] + term[3] + term[4];
   wire ovf_hi = sum > SUM_MAX;
   wire ovf_lo = sum < SUM_MIN;
   wire ovf_hit = sample_valid && (ovf_hi || ovf_lo);
   wire signed [9:0] sat = ovf_hi ? SUM_MAX : (ovf_lo ? SUM_MIN : sum);

   // overflow flag, set beats read clear
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ovf_reg <= 1'b0;
      end else if (hold) begin
         ovf_reg <= 1'b0;
      end else if (ovf_hit) begin
         ovf_reg <= 1'b1;
      end else if (rd_csr) begin
         ovf_reg <= 1'b0;
      end
   end

   // trim registers and fuse copy sequence
   logic [1:0] copy_ev;
   tptc_trim_t trim_next [2];
   logic armed_next [2];
   for (genvar g = 0; g < 2; g++) begin : g_trim
      localparam logic [7:0] OFS = (g == 0) ? `TPTC_OFS_NTRIM : `TPTC_OFS_PTRIM;
      wire wr_g = reg_wr && (reg_addr == OFS);
      wire bus_other = (reg_wr || reg_rd) && !wr_g;
      wire fuse_wr = wr_g && !fsel_reg && reg_wdata[0];
      wire first = fuse_wr && !armed_reg[g];
      wire second = fuse_wr && armed_reg[g];
      assign copy_ev[g] = second;
      assign trim_next[g] = second ? {fuse_burned[g], 1'b1} :
                            first ? {trim_reg[g][6:1], 1'b1} :
                            wr_g ? reg_wdata[6:0] : trim_reg[g];
      assign armed_next[g] = first ? 1'b1 : ((wr_g || bus_other) ? 1'b0 : armed_reg[g]);
      always_ff @(posedge clk_sys or negedge rstn) begin
         if (!rstn) begin
            trim_reg[g] <= `TPTC_RST_TRIM;
            armed_reg[g] <= 1'b0;
         end else if (hold) begin
            trim_reg[g] <= `TPTC_RST_TRIM;
            armed_reg[g] <= 1'b0;
         end else begin
            trim_reg[g] <= trim_next[g];
            armed_reg[g] <= armed_next[g];
         end
      end
   end

   // interrupt status, set beats write-one clear
   wire [1:0] int_ev = {|copy_ev, ovf_hit};
   wire [1:0] istat_next = (istat_reg & ~(wr_istat ? reg_wdata[1:0] : 2'h0)) | int_ev;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         istat_reg <= 2'h0;
         irq_reg <= 1'b0;
      end else if (hold) begin
         istat_reg <= 2'h0;
         irq_reg <= 1'b0;
      end else begin
         istat_reg <= istat_next;
         irq_reg <= |(istat_reg & imask_reg);
      end
   end

   // amplitude decode
   wire [4:0] eff_scale = drv_reg[`TPTC_BIT_FLOAT] ? 5'h00 : drv_reg[4:0];
   wire is_step = (eff_scale != 5'h00) && (eff_scale <= `TPTC_SCALE_MAXSTEP);
   wire is_full = eff_scale == `TPTC_SCALE_FULL;
   wire tptc_amp_t amp_next = (eff_scale == 5'h00) ? TPTC_AMP_FLOAT :
                              is_step ? TPTC_AMP_STEP :
                              is_full ? TPTC_AMP_FULL : TPTC_AMP_RSVD;
   wire [4:0] steps_next = (is_step || is_full) ? eff_scale : 5'h00;
   wire float_next = !(is_step || is_full);

   // line driver and sample outputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         float_reg <= 1'b1;
         amp_mode_reg <= TPTC_AMP_FLOAT;
         amp_steps_reg <= 5'h00;
         dac_code_reg <= 8'sh00;
      end else if (hold) begin
         float_reg <= 1'b1;
         amp_mode_reg <= TPTC_AMP_FLOAT;
         amp_steps_reg <= 5'h00;
         dac_code_reg <= 8'sh00;
      end else begin
         float_reg <= float_next;
         amp_mode_reg <= amp_next;
         amp_steps_reg <= steps_next;
         if (sample_valid) dac_code_reg <= sat[7:0];
      end
   end

   // trim outputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         trim_mag_reg <= '0;
         trim_neg_reg <= 2'h0;
         trim_ovr_reg <= 2'h0;
         fuse_blow_reg <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            trim_mag_reg[i] <= trim_reg[i][5:1];
            trim_neg_reg[i] <= trim_reg[i][6];
            trim_ovr_reg[i] <= !trim_reg[i][0] && !fpin_s;
            fuse_blow_reg[i] <= (!trim_reg[i][0] && fpin_s && atm_s) ?
                                trim_reg[i][6:1] : 6'h00;
         end
      end
   end

   // read data mux
   wire [7:0] rd_val =
      (reg_addr == `TPTC_OFS_DRV) ? drv_reg :
      (reg_addr == `TPTC_OFS_CSR) ? {5'h00, ovf_reg, csr_rsv_reg} :
      (reg_addr == `TPTC_OFS_WADR) ? wadr_reg :
      (reg_addr == `TPTC_OFS_NTRIM) ? {1'b0, trim_reg[0]} :
      (reg_addr == `TPTC_OFS_PTRIM) ? {1'b0, trim_reg[1]} :
      (reg_addr == `TPTC_OFS_FSEL) ? {7'h00, fsel_reg} :
      (reg_addr == `TPTC_OFS_ISTAT) ? {6'h00, istat_reg} :
      (reg_addr == `TPTC_OFS_IMASK) ? {6'h00, imask_reg} : 8'h00;

   // read data, valid only the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= reg_rd ? rd_val : 8'h00;
      end
   end

   assign reg_rdata = rdata_reg;
   assign line_float = float_reg;
   assign amp_mode = amp_mode_reg;
   assign amp_steps = amp_steps_reg;
   assign dac_code = dac_code_reg;
   assign trim_mag = trim_mag_reg;
   assign trim_neg = trim_neg_reg;
   assign trim_override = trim_ovr_reg;
   assign fuse_blow = fuse_blow_reg;
   assign fuse_sense_en = {armed_reg[1], armed_reg[0]};
   assign irq = irq_reg;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_ovf_set_flag: assert property (
      ovf_hit && !hold |=> ovf_reg && istat_reg[`TPTC_INT_OVF])
      else $error("overflow not flagged");
   a_ovf_read_clear: assert property (
      rd_csr && ovf_reg && !ovf_hit && !hold |=> !ovf_reg && reg_rdata[`TPTC_BIT_OVF])
      else $error("overflow read clear wrong");
   a_ovf_sticky_hold: assert property (ovf_reg && !rd_csr && !hold |=> ovf_reg)
      else $error("overflow flag dropped");
   a_dac_saturate: assert property (
      sample_valid && !hold |=> dac_code_reg <= DAC_MAX && dac_code_reg >= -DAC_MAX)
      else $error("dac not saturated");
   a_float_as_zero: assert property (
      !hold && drv_reg[`TPTC_BIT_FLOAT]
      |=> amp_mode_reg == TPTC_AMP_FLOAT && amp_steps_reg == 5'h00 && float_reg)
      else $error("float bit ignored");
   a_full_scale: assert property (
      !hold && drv_reg == 8'h15 |=> amp_mode_reg == TPTC_AMP_FULL && amp_steps_reg == 5'h15)
      else $error("full scale wrong");
   a_tmpl_store: assert property (
      tmpl_we && !hold |=> tmpl_mem[$past(wa_idx)] == $past(wr_val))
      else $error("template not stored");
   a_bad_addr_kept: assert property (
      wr_wdat && !wa_ok && !hold |=> tmpl_mem[0] == $past(tmpl_mem[0])
      && tmpl_mem[`TPTC_TAP_COUNT] == $past(tmpl_mem[`TPTC_TAP_COUNT]))
      else $error("undefined address wrote entry");
   a_hold_clears: assert property (
      hold |=> drv_reg == `TPTC_RST_DRV && wadr_reg == `TPTC_RST_WADR
      && trim_reg[0] == `TPTC_RST_TRIM && !ovf_reg)
      else $error("hold did not reset");
   a_blow_gated: assert property (
      fuse_blow_reg[0] != 6'h00 |-> $past(fpin_s) && $past(atm_s) && !$past(trim_reg[0][0]))
      else $error("fuse blown without enable");
   a_fuse_copy: assert property (
      g_trim[1].second && !hold |=> trim_reg[1] == {$past(fuse_burned[1]), 1'b1})
      else $error("fuse copy missed");

   c_overflow: cover property (ovf_hit ##[1:8] rd_csr);
   c_fuse_copy: cover property (g_trim[1].first ##1 g_trim[1].second);
   c_tmpl_write: cover property (wr_wadr ##1 tmpl_we);
   c_blow: cover property (fuse_blow_reg[0] != 6'h00);
endmodule : tptc_ctrl

// file: tptc_ctrl_note_end.sv
`timescale 1ns/1ps

// file: tptc_tb.sv
`timescale 1ns/1ps
`include "tptc_cfg.svh"
module testbench;
   import tptc_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic tx_line_unit_hold = 1'b0;
   logic fuse_program_pin = 1'b0;
   logic analog_test_pin = 1'b0;
   logic [1:0][5:0] fuse_burned = '0;
   logic sample_valid = 1'b0;
   logic [4:0] sample_tap = 5'h00;
   logic [4:0] sample_ui_mark = 5'h00;
   logic line_float;
   tptc_amp_t amp_mode;
   logic [4:0] amp_steps;
   logic signed [7:0] dac_code;
   logic [1:0][4:0] trim_mag;
   logic [1:0] trim_neg;
   logic [1:0] trim_override;
   logic [1:0][5:0] fuse_blow;
   logic [1:0] fuse_sense_en;
   logic irq;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [7:0] scale_wr [7] = '{8'h00, 8'h01, 8'h14, 8'h15, 8'h16, 8'h1f, 8'h85};
   logic [7:0] scale_exp [7] = '{8'h80, 8'h21, 8'h34, 8'h75, 8'hc0, 8'hc0, 8'h80};

   tptc_ctrl dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_line_unit_hold(tx_line_unit_hold), .fuse_program_pin(fuse_program_pin),
      .analog_test_pin(analog_test_pin), .fuse_burned(fuse_burned),
      .sample_valid(sample_valid), .sample_tap(sample_tap), .sample_ui_mark(sample_ui_mark),
      .line_float(line_float), .amp_mode(amp_mode), .amp_steps(amp_steps),
      .dac_code(dac_code), .trim_mag(trim_mag), .trim_neg(trim_neg),
      .trim_override(trim_override), .fuse_blow(fuse_blow), .fuse_sense_en(fuse_sense_en),
      .irq(irq));

   // 25 mhz clock
   always #20 clk_sys = ~clk_sys;

   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails = fails + 1;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one bus cycle, driven just after an edge
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      check("reg_rdata", reg_rdata, exp);
   endtask : rd

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   // one sample request, result looked at after the answering edge
   task automatic sample(input logic [4:0] tap, input logic [4:0] mark, input logic [7:0] exp);
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      sample_tap <= tap;
      sample_ui_mark <= mark;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      #1;
      check("dac_code", dac_code, exp);
   endtask : sample

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(`TPTC_OFS_DRV, 8'h80);
      rd(`TPTC_OFS_CSR, 8'h01);
      rd(`TPTC_OFS_WADR, 8'h00);
      rd(`TPTC_OFS_NTRIM, 8'h00);
      rd(`TPTC_OFS_FSEL, 8'h00);
      rd(`TPTC_OFS_WDAT, 8'h00);
      rd(8'h10, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 7; i++) begin
         wr(`TPTC_OFS_DRV, scale_wr[i]);
         wait_cyc(2);
         check("amp_decode", {line_float, amp_mode, amp_steps}, scale_exp[i]);
      end
      rd(`TPTC_OFS_DRV, 8'h85);
      $display("test amplitude decode done");
      wr(`TPTC_OFS_WADR, 8'h18);
      wr(`TPTC_OFS_WDAT, 8'h3f);
      wr(`TPTC_OFS_WADR, 8'h19);
      wr(`TPTC_OFS_WDAT, 8'h3f);
      wr(`TPTC_OFS_WADR, 8'h20);
      wr(`TPTC_OFS_WDAT, 8'h7e);
      sample(5'h03, 5'h03, 8'h7e);
      sample(5'h04, 5'h01, 8'hc2);
      rd(`TPTC_OFS_CSR, 8'h01);
      wr(`TPTC_OFS_WADR, 8'h1d);
      wr(`TPTC_OFS_WDAT, 8'h01);
      wr(`TPTC_OFS_WADR, 8'hc0);
      wr(`TPTC_OFS_WDAT, 8'h01);
      sample(5'h03, 5'h1f, 8'h7e);
      sample(5'h00, 5'h1f, 8'h00);
      bus(1'b1, 1'b0, `TPTC_OFS_WADR, 8'h1a);
      bus(1'b1, 1'b0, `TPTC_OFS_WDAT, 8'h3f);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      sample(5'h03, 5'h07, 8'h7f);
      wait_cyc(2);
      rd(`TPTC_OFS_CSR, 8'h05);
      rd(`TPTC_OFS_CSR, 8'h01);
      $display("test template and overflow done");
      rd(`TPTC_OFS_ISTAT, 8'h01);
      check("irq", {7'h00, irq}, 8'h00);
      wr(`TPTC_OFS_IMASK, 8'h01);
      wait_cyc(2);
      check("irq", {7'h00, irq}, 8'h01);
      wr(`TPTC_OFS_ISTAT, 8'h01);
      wait_cyc(2);
      check("irq", {7'h00, irq}, 8'h00);
      rd(`TPTC_OFS_ISTAT, 8'h00);
      $display("test interrupt done");
      wr(`TPTC_OFS_WADR, 8'h55);
      wr(`TPTC_OFS_DRV, 8'h1f);
      @(posedge clk_sys);
      tx_line_unit_hold <= 1'b1;
      repeat (3) @(posedge clk_sys);
      tx_line_unit_hold <= 1'b0;
      rd(`TPTC_OFS_WADR, 8'h00);
      rd(`TPTC_OFS_DRV, 8'h80);
      rd(`TPTC_OFS_IMASK, 8'h00);
      sample(5'h03, 5'h07, 8'h00);
      $display("test hold done");
      wr(`TPTC_OFS_FSEL, 8'h01);
      wr(`TPTC_OFS_NTRIM, 8'h54);
      wait_cyc(4);
      check("trim_field", {2'h0, trim_neg[0], trim_mag[0]}, 8'h2a);
      check("override", {6'h00, trim_override}, 8'h03);
      check("fuse_blow", {2'h0, fuse_blow[0]}, 8'h00);
      @(posedge clk_sys);
      fuse_program_pin <= 1'b1;
      wait_cyc(4);
      check("override", {6'h00, trim_override}, 8'h00);
      check("fuse_blow", {2'h0, fuse_blow[0]}, 8'h00);
      @(posedge clk_sys);
      analog_test_pin <= 1'b1;
      wait_cyc(4);
      check("fuse_blow", {2'h0, fuse_blow[0]}, 8'h2a);
      @(posedge clk_sys);
      fuse_program_pin <= 1'b0;
      analog_test_pin <= 1'b0;
      rd(`TPTC_OFS_NTRIM, 8'h54);
      $display("test trim control done");
      @(posedge clk_sys);
      fuse_burned[1] <= 6'h33;
      fuse_burned[0] <= 6'h07;
      wr(`TPTC_OFS_FSEL, 8'h00);
      bus(1'b1, 1'b0, `TPTC_OFS_PTRIM, 8'h01);
      bus(1'b1, 1'b0, `TPTC_OFS_PTRIM, 8'h01);
      #1;
      check("fuse_sense_en", {6'h00, fuse_sense_en}, 8'h02);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      check("fuse_sense_en", {6'h00, fuse_sense_en}, 8'h00);
      rd(`TPTC_OFS_PTRIM, 8'h67);
      rd(`TPTC_OFS_ISTAT, 8'h02);
      check("irq", {7'h00, irq}, 8'h00);
      wr(`TPTC_OFS_NTRIM, 8'h01);
      rd(`TPTC_OFS_NTRIM, 8'h55);
      wr(`TPTC_OFS_NTRIM, 8'h01);
      rd(`TPTC_OFS_NTRIM, 8'h55);
      wr(`TPTC_OFS_FSEL, 8'h01);
      wr(`TPTC_OFS_PTRIM, 8'h66);
      rd(`TPTC_OFS_PTRIM, 8'h66);
      $display("test fuse copy done");
      finish_test();
   end
endmodule : testbench
